//--- bench/adc_pair_converter_model.sv
module adc_pair_converter_model (
    input  wire logic        clk,
    input  wire logic        slow,
    input  wire logic        convStart,
    input  wire logic        convPair,
    output logic             convDone,
    output logic [15:0]      sampleA,
    output logic [15:0]      sampleB
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] idx;
    initial begin
        convDone = 1'b0;
        idx = 16'h0000;
        sampleA = 16'h5A5A;
        sampleB = 16'hA5A5;
        forever begin
            @(posedge clk);
            if (convStart) begin
                repeat (slow ? 5 : 0) @(posedge clk);
                #1;
                idx = idx + 16'h0001;
                // both sides of one pair are taken at the same instant
                sampleA = convPair ? 16'hC000 - idx * 16'h0007 : 16'h1200 + idx * 16'h0005;
                sampleB = ~sampleA + {15'h0000, convPair};
                convDone = 1'b1;
                @(posedge clk);
                #1;
                convDone = 1'b0;
                // stale codes must not pass for fresh ones
                sampleA = ~sampleA;
                sampleB = ~sampleB;
            end
        end
    end
endmodule

//--- bench/adc_pair_select_sequencer_averager_tb.sv
module adc_pair_select_sequencer_averager_tb
    import adc_pair_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, ce, csFall, pairSelect, seqEnable, avgModeSelect;
    logic        ratioWrite, extendEnable, slow, convDone, convStart, convPair;
    logic        resultValid, wideActive, busy, firstPair;
    ratio_t      ratioField;
    logic [15:0] sampleA, sampleB;
    logic [17:0] resultA, resultB;
    logic [23:0] sA, sB;
    int          errors, checks, starts, cyc, last, minGap;

    adc_pair_sequencer u_adc_pair_sequencer (.clk(clk), .rst_n(rst_n), .ce(ce),
        .csFall(csFall), .pairSelect(pairSelect), .seqEnable(seqEnable),
        .avgModeSelect(avgModeSelect), .ratioField(ratioField), .ratioWrite(ratioWrite),
        .extendEnable(extendEnable), .convDone(convDone), .sampleA(sampleA), .sampleB(sampleB),
        .convStart(convStart), .convPair(convPair), .resultA(resultA), .resultB(resultB),
        .resultValid(resultValid), .wideActive(wideActive), .busy(busy));
    adc_pair_converter_model u_adc_pair_converter_model (.clk(clk), .slow(slow),
        .convStart(convStart), .convPair(convPair), .convDone(convDone),
        .sampleA(sampleA), .sampleB(sampleB));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (convDone === 1'b1) begin
            sA = sA + {8'h00, sampleA};
            sB = sB + {8'h00, sampleB};
        end
        if (convStart === 1'b1) begin
            if (starts == 0) firstPair = convPair;
            else if (cyc - last < minGap) minGap = cyc - last;
            last = cyc;
            starts++;
        end
    end

    task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic setRatio(input ratio_t code);
        @(posedge clk);
        #1 ratioField = code;
        ratioWrite = 1'b1;
        @(posedge clk);
        #1 ratioWrite = 1'b0;
    endtask

    // n of 0 runs a burst without checking it, to let a ratio change settle
    task automatic burst(input int n, input logic pair, input logic poke, input logic wide);
        int lg;
        int t;
        lg = $clog2(n);
        // two idle clocks keep pair changes and burst starts under the host rate limits
        repeat (2) @(posedge clk);
        #1 csFall = 1'b1;
        @(posedge clk);
        #1 csFall = 1'b0;
        starts = 0;
        sA = 24'h000000;
        sB = 24'h000000;
        minGap = 99;
        if (poke) begin
            repeat (2) @(posedge clk);
            #1 csFall = 1'b1;
            @(posedge clk);
            #1 csFall = 1'b0;
        end
        t = 0;
        while (resultValid !== 1'b1 && t < 2000) begin
            @(posedge clk);
            #1 t++;
        end
        if (t == 2000) errors++;
        if (n > 0) begin
            check("starts", starts, n);
            check("pair", {23'h0, firstPair}, {23'h0, pair});
            check("resultA", {6'h00, resultA}, wide ? (sA << 2) >> lg : sA >> lg);
            check("resultB", {6'h00, resultB}, wide ? (sB << 2) >> lg : sB >> lg);
            check("wide", {23'h0, wideActive}, {23'h0, wide});
            check("busy", {23'h0, busy}, 24'h000000);
        end
    endtask

    initial begin
        {rst_n, csFall, pairSelect, seqEnable, avgModeSelect, ratioWrite, extendEnable} = 7'h00;
        {ce, slow, ratioField} = 5'h10;
        errors = 0;
        checks = 0;
        starts = 0;
        cyc = 0;
        last = 0;
        minGap = 0;
        {sA, sB} = 48'h0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        check("idle", {22'h0, resultValid, busy}, 24'h000000);
        burst(1, 1'b0, 1'b0, 1'b0);
        pairSelect = 1'b1;
        slow = 1'b1;
        burst(1, 1'b1, 1'b1, 1'b0);
        $display("test manual select done");
        seqEnable = 1'b1;
        slow = 1'b0;
        for (int i = 0; i < 3; i++) begin
            burst(1, i[0], 1'b0, 1'b0);
        end
        $display("test sequencer done");
        seqEnable = 1'b0;
        pairSelect = 1'b0;
        setRatio(3'h2);
        burst(1, 1'b0, 1'b0, 1'b0);
        burst(0, 1'b0, 1'b0, 1'b0);
        burst(4, 1'b0, 1'b0, 1'b0);
        check("gap", minGap, 24'h000004);
        $display("test ratio latency done");
        for (int c = 1; c <= 5; c++) begin
            extendEnable = c[0];
            slow = c[1];
            setRatio(c[2:0]);
            burst(0, 1'b0, 1'b0, 1'b0);
            burst(0, 1'b0, 1'b0, 1'b0);
            burst(1 << c, 1'b0, 1'b0, c[0]);
        end
        $display("test ratios done");
        avgModeSelect = 1'b1;
        burst(1, 1'b0, 1'b0, 1'b0);
        $display("test other mode done");
        avgModeSelect = 1'b0;
        setRatio(3'h6);
        burst(0, 1'b0, 1'b0, 1'b0);
        burst(1, 1'b0, 1'b0, 1'b0);
        $display("test invalid ratio done");
        ce = 1'b0;
        @(posedge clk);
        #1 csFall = 1'b1;
        repeat (3) @(posedge clk);
        #1 csFall = 1'b0;
        check("frozen", {22'h0, resultValid, busy}, 24'h000002);
        check("held", starts, 24'h000001);
        ce = 1'b1;
        $display("test clock enable done");
        give_verdict();
    end

    initial begin
        repeat (50000) @(posedge clk);
        errors++;
        give_verdict();
    end
endmodule

//--- common/adc_pair_pkg.sv
package adc_pair_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_GAP  = 3'b100
    } seq_state_e;
    typedef logic [2:0] ratio_t;
endpackage

//--- common/adc_pair_regs.svh
`ifndef ADC_PAIR_REGS_SVH
`define ADC_PAIR_REGS_SVH

`define CLK_PERIOD_NS    100
`define CONV_PERIOD_NS16 333
`define CONV_PERIOD_NSLO 250
`define CONV_CYC16       ((`CONV_PERIOD_NS16 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYCLO       ((`CONV_PERIOD_NSLO + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RATIO_OFF        3'h0
`define RATIO_MAX        3'h5
`define RATIO_RESET      3'h0
`define EXT_BITS         2
`endif

//--- rtl/adc_pair_sequencer.sv
`include "adc_pair_regs.svh"

module adc_pair_sequencer
    import adc_pair_pkg::*;
#(
    parameter int NATIVE_W = 16
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    input  wire logic                  csFall,
    input  wire logic                  pairSelect,
    input  wire logic                  seqEnable,
    input  wire logic                  avgModeSelect,
    input  wire ratio_t                ratioField,
    input  wire logic                  ratioWrite,
    input  wire logic                  extendEnable,
    input  wire logic                  convDone,
    input  wire logic [NATIVE_W-1:0]   sampleA,
    input  wire logic [NATIVE_W-1:0]   sampleB,
    output logic                       convStart,
    output logic                       convPair,
    output logic [NATIVE_W+1:0]        resultA,
    output logic [NATIVE_W+1:0]        resultB,
    output logic                       resultValid,
    output logic                       wideActive,
    output logic                       busy
);
    localparam int ACC_W = NATIVE_W + 5;
    // pacing rounds up to whole clocks: a burst never outruns the converter, at some rate cost
    localparam int CONV_CYC = (NATIVE_W == 16) ? `CONV_CYC16 : `CONV_CYCLO;
    localparam logic [2:0] GAP_LAST = 3'(CONV_CYC - 1);

    // only the three converter widths have a pacing count and a result layout
    if (NATIVE_W != 16 && NATIVE_W != 14 && NATIVE_W != 12) begin
        $error("NATIVE_W must be 12, 14 or 16");
    end

    seq_state_e       state;
    ratio_t           ratioPend;
    ratio_t           ratioMid;
    ratio_t           ratioAct;
    logic             seqPair;
    logic             burstAvg;
    logic             burstWide;
    ratio_t           burstRatio;
    logic [5:0]       burstCount;
    logic [2:0]       timer;
    logic [ACC_W-1:0] accA;
    logic [ACC_W-1:0] accB;

    logic             ratioValid;
    logic             avgNow;
    logic             curPair;
    logic [5:0]       burstLen;
    logic             lastSample;
    logic             gapDone;
    logic [ACC_W-1:0] sumA;
    logic [ACC_W-1:0] sumB;
    logic             startIdle;
    logic             startGap;

    assign ratioValid = ratioAct != `RATIO_OFF && ratioAct <= `RATIO_MAX;
    assign avgNow     = !avgModeSelect && ratioValid;
    // sequencing overrides the manual pair bit entirely
    assign curPair    = seqEnable ? seqPair : pairSelect;
    assign burstLen   = burstAvg ? 6'(1 << burstRatio) : 6'h01;
    assign lastSample = (burstCount + 6'h01) == burstLen;
    assign gapDone    = timer >= GAP_LAST;
    assign sumA       = accA + ACC_W'(sampleA);
    assign sumB       = accB + ACC_W'(sampleB);
    assign startIdle  = ce && state == ST_IDLE && csFall;
    assign startGap   = ce && state == ST_GAP && gapDone;

    // decimation: divide by n, keep two extra fraction bits when widened
    function automatic logic [NATIVE_W+1:0] decimate(input logic [ACC_W-1:0] acc,
                                                     input ratio_t r,
                                                     input logic wide);
        logic [ACC_W+1:0] scaled;
        scaled = {acc, 2'b00} >> r;
        if (wide)
            decimate = scaled[NATIVE_W+1:0];
        else
            decimate = {2'b00, scaled[NATIVE_W+1:2]};
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else if (ce) begin
            unique case (state)
                ST_IDLE: if (csFall) state <= ST_WAIT;
                ST_WAIT: if (convDone) state <= lastSample ? ST_IDLE : ST_GAP;
                ST_GAP:  if (gapDone) state <= ST_WAIT;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            convStart <= 1'b0;
            convPair  <= 1'b0;
        end else if (ce) begin
            convStart <= startIdle || startGap;
            if (startIdle)
                convPair <= curPair;
        end
    end

    // internal starts are paced from the previous start, not from done
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer <= 3'h0;
        end else if (ce) begin
            if (convStart)
                timer <= 3'h1;
            else if (!gapDone)
                timer <= timer + 3'h1;
        end
    end

    // ratio writes travel two conversion starts before they count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ratioPend <= `RATIO_RESET;
            ratioMid  <= `RATIO_RESET;
            ratioAct  <= `RATIO_RESET;
        end else if (ce) begin
            if (ratioWrite)
                ratioPend <= ratioField;
            if (convStart) begin
                ratioMid <= ratioPend;
                ratioAct <= ratioMid;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            burstAvg   <= 1'b0;
            burstWide  <= 1'b0;
            burstRatio <= `RATIO_RESET;
        end else if (startIdle) begin
            burstAvg   <= avgNow;
            burstWide  <= avgNow && extendEnable;
            burstRatio <= avgNow ? ratioAct : `RATIO_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accA       <= '0;
            accB       <= '0;
            burstCount <= 6'h00;
        end else if (startIdle) begin
            accA       <= '0;
            accB       <= '0;
            burstCount <= 6'h00;
        end else if (ce && state == ST_WAIT && convDone) begin
            accA       <= sumA;
            accB       <= sumB;
            burstCount <= burstCount + 6'h01;
        end
    end

    // result stays readable until the next chip select fall
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            resultA     <= '0;
            resultB     <= '0;
            resultValid <= 1'b0;
            wideActive  <= 1'b0;
        end else if (startIdle) begin
            resultValid <= 1'b0;
        end else if (ce && state == ST_WAIT && convDone && lastSample) begin
            resultA     <= decimate(sumA, burstRatio, burstWide);
            resultB     <= decimate(sumB, burstRatio, burstWide);
            resultValid <= 1'b1;
            wideActive  <= burstWide;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seqPair <= 1'b0;
        end else if (ce) begin
            if (!seqEnable)
                seqPair <= 1'b0;
            else if (state == ST_WAIT && convDone && lastSample)
                seqPair <= !seqPair;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            busy <= 1'b0;
        else if (ce)
            busy <= startIdle || (busy && !(state == ST_WAIT && convDone && lastSample));
    end

    a_pair_zero_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        startIdle && !seqEnable && !pairSelect |=> convStart && !convPair)
        else $error("manual pair zero not converted");
    a_pair_one_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        startIdle && !seqEnable && pairSelect |=> convStart && convPair)
        else $error("manual pair one not converted");
    a_seq_ignores_select: assert property (@(posedge clk) disable iff (!rst_n)
        startIdle && seqEnable |=> convPair == $past(seqPair))
        else $error("sequencer pair not used");
    a_seq_alternates: assert property (@(posedge clk) disable iff (!rst_n)
        ce && seqEnable && $past(seqEnable) && $rose(resultValid)
        |-> seqPair != $past(seqPair))
        else $error("sequencer did not advance after result");
    a_seq_restart_zero: assert property (@(posedge clk) disable iff (!rst_n)
        $past(ce) && !$past(seqEnable) |-> !seqPair)
        else $error("sequencer not parked at pair zero");
    a_ratio_latency: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(ratioAct) |-> $past(convStart) && $past(ratioMid) == ratioAct)
        else $error("ratio changed without a conversion");
    a_burst_pacing: assert property (@(posedge clk) disable iff (!rst_n)
        convStart && $past(state) == ST_GAP |-> $past(timer) >= GAP_LAST)
        else $error("internal conversion started too early");
    a_start_source: assert property (@(posedge clk) disable iff (!rst_n)
        convStart |-> $past(csFall && state == ST_IDLE) || $past(state) == ST_GAP)
        else $error("conversion started without cause");
    a_acc_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        startIdle |=> accA == '0 && accB == '0 && !resultValid)
        else $error("samples not discarded at burst start");
    a_native_width: assert property (@(posedge clk) disable iff (!rst_n)
        resultValid && !wideActive |-> resultA[NATIVE_W+1:NATIVE_W] == 2'b00)
        else $error("native result exceeds native width");
    a_wide_needs_avg: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(wideActive) |-> burstAvg && $past(burstWide))
        else $error("widened output without averaging");
    a_burst_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(resultValid) |-> $past(burstCount) + 6'h01 == burstLen)
        else $error("result before burst complete");
endmodule
